/* File: rtl/phase_mon.sv */
`timescale 1ns/100ps
`include "term_cfg.svh"
module phase_mon (
  // Bus levels
  input  wire logic irdy_n,
  input  wire logic trdy_n,
  input  wire logic stop_n,
  input  wire logic frame_n,
  // Decoded events
  output logic      done,
  output logic      xfer,
  output logic      last
);
  // Completion and transfer decode
  always_comb begin
    done = ~irdy_n & (~stop_n | ~trdy_n);
    xfer = ~irdy_n & ~trdy_n;
    last = done & frame_n;
  end
endmodule // phase_mon

/* File: rtl/term_cfg.svh */
// Behaviour
// - Retry: stop without trdy on first phase
// - Disconnect with data: trdy and stop together
// - Disconnect without data only after a transfer
// - Abort: drop devsel, assert stop, no trdy
// - Stop with trdy allowed on single phase
// - Invalidate writes disconnect only at line boundary
// - Phase completes on irdy with stop or trdy
// - Word moves whenever irdy and trdy both asserted
// - Stop held until last phase completes
// - Target signals frozen once committed until completion
// - Master drops frame at first irdy after stop
// - Master may raise irdy at once after stop
// - Master finishes invalidate line with plain write; the master here has no invalidate command
// - Target deasserts then releases its signals
// - Master drops irdy after last phase
// - Trdy dropped after phase, stop kept
// - Wait states come before stop, never with
// - Neither trdy nor stop means wait state
// - Frame and irdy commit two more phases; the master here commits to one more
// - Master handles every termination kind
// - Bus returns to normal after any termination
`ifndef TERM_CFG_SVH
`define TERM_CFG_SVH
`define TERM_CNT_W      4
`define TERM_MAX_WAIT   4'h3
`define TERM_IRDY_LAT   4'h1
`define TERM_LINE_W     3
`endif

/* File: rtl/term_if.sv */
`timescale 1ns/100ps
// Active-low bus signals; target oe is high while it drives its pins
interface term_if (input wire logic core_clk);
  logic frame_n;
  logic irdy_n;
  logic trdy_n_o;
  logic stop_n_o;
  logic devsel_n_o;
  logic tgt_oe;
  logic trdy_n;
  logic stop_n;
  logic devsel_n;
  // Pulled-up wire levels
  assign trdy_n   = tgt_oe ? trdy_n_o : 1'b1;
  assign stop_n   = tgt_oe ? stop_n_o : 1'b1;
  assign devsel_n = tgt_oe ? devsel_n_o : 1'b1;
  modport tgt (input frame_n, irdy_n, output trdy_n_o, stop_n_o, devsel_n_o, tgt_oe);
  modport mst (output frame_n, irdy_n, input trdy_n, stop_n, devsel_n);
endinterface // term_if

/* File: rtl/term_master.sv */
`timescale 1ns/100ps
`include "term_cfg.svh"
module term_master (
  // Clock and reset
  input  wire logic core_clk,
  input  wire logic rst_n,
  // Bus
  term_if.mst       bus,
  // Request
  input  wire logic start,
  input  wire logic burst,
  input  wire logic data_rdy,
  // Result
  output logic      busy_ff,
  output term_pkg::end_kind_type kind_ff
);
  term_pkg::mst_state_type st_ff, nxt_st;
  logic frame_ff, irdy_ff, moved_ff, stopped_ff, nxt_frame, nxt_irdy, nxt_moved, nxt_stopped;
  logic nxt_busy;
  term_pkg::end_kind_type nxt_kind;
  logic done, xfer;
  phase_mon u_mon (.irdy_n(~irdy_ff), .trdy_n(bus.trdy_n), .stop_n(bus.stop_n),
                   .frame_n(~frame_ff), .done(done), .xfer(xfer), .last());
  // Next-state logic
  always_comb begin
    nxt_st = st_ff; nxt_frame = frame_ff; nxt_irdy = irdy_ff; nxt_moved = moved_ff;
    nxt_stopped = stopped_ff; nxt_busy = busy_ff; nxt_kind = kind_ff;
    case (st_ff)
      term_pkg::M_IDLE: begin
        if (start) begin
          nxt_st = term_pkg::M_BURST; nxt_frame = 1'b1; nxt_busy = 1'b1;
          nxt_moved = 1'b0; nxt_stopped = 1'b0; nxt_kind = term_pkg::END_NONE;
        end
      end
      term_pkg::M_BURST: begin
        // Stop seen: raise irdy at once, drop frame with it
        if (~bus.stop_n & ~done) nxt_stopped = 1'b1;
        if (done) nxt_moved = moved_ff | xfer;
        if (~bus.stop_n & bus.trdy_n) begin
          nxt_irdy = 1'b1; nxt_frame = ~irdy_ff | done ? 1'b0 : frame_ff;
        end else if (~bus.stop_n | (~burst & data_rdy)) begin
          nxt_irdy = 1'b1;
          if (irdy_ff & ~done) nxt_frame = frame_ff; else nxt_frame = 1'b0;
        end else if (irdy_ff & ~done) begin
          nxt_irdy = 1'b1;
        end else begin
          nxt_irdy = data_rdy;
        end
        if (~nxt_frame) nxt_st = term_pkg::M_LAST;
      end
      term_pkg::M_LAST: begin
        if (done) nxt_moved = moved_ff | xfer;
        if (~bus.stop_n) nxt_stopped = 1'b1;
        if (done) begin
          nxt_irdy = 1'b0; nxt_st = term_pkg::M_END;
          if (bus.devsel_n & ~bus.stop_n) nxt_kind = term_pkg::END_ABORT;
          else if (~(stopped_ff | ~bus.stop_n)) nxt_kind = term_pkg::END_DONE;
          else if (moved_ff | xfer) nxt_kind = term_pkg::END_DISC;
          else nxt_kind = term_pkg::END_RETRY;
        end
      end
      term_pkg::M_END: begin
        nxt_busy = 1'b0; nxt_st = term_pkg::M_IDLE;
      end
      default: begin
        nxt_st = term_pkg::M_IDLE; nxt_frame = 1'b0; nxt_irdy = 1'b0; nxt_busy = 1'b0;
      end
    endcase
  end
  // State registers
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      st_ff <= term_pkg::M_IDLE; frame_ff <= 1'b0; irdy_ff <= 1'b0; moved_ff <= 1'b0;
      stopped_ff <= 1'b0; busy_ff <= 1'b0; kind_ff <= term_pkg::END_NONE;
    end else begin
      st_ff <= nxt_st; frame_ff <= nxt_frame; irdy_ff <= nxt_irdy; moved_ff <= nxt_moved;
      stopped_ff <= nxt_stopped; busy_ff <= nxt_busy; kind_ff <= nxt_kind;
    end
  end
  // Pin drive, active low
  assign bus.frame_n = ~frame_ff;
  assign bus.irdy_n  = ~irdy_ff;
endmodule // term_master

/* File: rtl/term_pkg.sv */
package term_pkg;
  // Target sequencer states
  typedef enum logic [5:0] {
    T_IDLE  = 6'h01,
    T_WAIT  = 6'h02,
    T_DATA  = 6'h04,
    T_STOP  = 6'h08,
    T_TURN  = 6'h10,
    T_REL   = 6'h20
  } tgt_state_type;
  // Master sequencer states
  typedef enum logic [3:0] {
    M_IDLE  = 4'h1,
    M_BURST = 4'h2,
    M_LAST  = 4'h4,
    M_END   = 4'h8
  } mst_state_type;
  // Termination kinds seen by the master
  typedef enum logic [2:0] {
    END_NONE  = 3'h0,
    END_DONE  = 3'h1,
    END_RETRY = 3'h2,
    END_DISC  = 3'h3,
    END_ABORT = 3'h4
  } end_kind_type;
endpackage

/* File: rtl/term_target.sv */
`timescale 1ns/100ps
`include "term_cfg.svh"
module term_target (
  // Clock and reset
  input  wire logic core_clk,
  input  wire logic rst_n,
  // Bus
  term_if.tgt       bus,
  // Claim and internal conditions
  input  wire logic claim,
  input  wire logic busy,
  input  wire logic buf_full,
  input  wire logic fatal,
  input  wire logic mwi,
  input  wire logic line_end,
  input  wire logic ready,
  // Status
  output logic      word_ff,
  output logic      aborted_ff
);
  term_pkg::tgt_state_type st_ff, nxt_st;
  logic trdy_ff, stop_ff, dev_ff, oe_ff, moved_ff, first_ff;
  logic nxt_trdy, nxt_stop, nxt_dev, nxt_oe, nxt_moved, nxt_first, nxt_word, nxt_abt;
  logic done, xfer, last, may_disc;
  phase_mon u_mon (.irdy_n(bus.irdy_n), .trdy_n(~trdy_ff), .stop_n(~stop_ff),
                   .frame_n(bus.frame_n), .done(done), .xfer(xfer), .last(last));
  //////////////////////////////////////////////////////////////////////////
  // Disconnect of invalidate writes only at line boundary
  assign may_disc = ~mwi | line_end;
  // Next-state logic
  always_comb begin
    nxt_st = st_ff; nxt_trdy = trdy_ff; nxt_stop = stop_ff; nxt_dev = dev_ff;
    nxt_oe = oe_ff; nxt_moved = moved_ff; nxt_first = first_ff;
    nxt_word = xfer & (st_ff == term_pkg::T_DATA | st_ff == term_pkg::T_STOP);
    nxt_abt = aborted_ff;
    case (st_ff)
      term_pkg::T_IDLE: begin
        if (claim) begin
          nxt_st = term_pkg::T_WAIT; nxt_dev = 1'b1; nxt_oe = 1'b1;
          nxt_moved = 1'b0; nxt_first = 1'b1; nxt_abt = 1'b0;
        end
      end
      term_pkg::T_WAIT: begin
        // Neither strobe: wait state, not committed
        if (fatal) begin
          nxt_st = term_pkg::T_STOP; nxt_dev = 1'b0; nxt_stop = 1'b1;
          nxt_trdy = 1'b0; nxt_abt = 1'b1;
        end else if (first_ff & busy) begin
          nxt_st = term_pkg::T_STOP; nxt_stop = 1'b1;
        end else if (~first_ff & moved_ff & buf_full & may_disc) begin
          nxt_st = term_pkg::T_STOP; nxt_stop = 1'b1;
        end else if (ready) begin
          nxt_trdy = 1'b1;
          nxt_st = term_pkg::T_DATA;
          if (buf_full & may_disc) begin
            nxt_stop = 1'b1; nxt_st = term_pkg::T_STOP;
          end
        end
      end
      term_pkg::T_DATA: begin
        // Frozen until the phase completes
        if (done) begin
          nxt_moved = xfer; nxt_first = 1'b0;
          if (last) begin
            nxt_st = term_pkg::T_TURN; nxt_trdy = 1'b0; nxt_dev = 1'b0;
          end else if (~ready | (buf_full & may_disc)) begin
            // Back to a wait state; a disconnect is chosen there
            nxt_trdy = 1'b0; nxt_st = term_pkg::T_WAIT;
          end
        end
      end
      term_pkg::T_STOP: begin
        if (done) begin
          nxt_trdy = 1'b0;
          nxt_first = 1'b0;
          if (last) begin
            nxt_st = term_pkg::T_TURN; nxt_stop = 1'b0; nxt_dev = 1'b0;
          end
        end
      end
      term_pkg::T_TURN: begin
        nxt_oe = 1'b0; nxt_st = term_pkg::T_IDLE;
      end
      default: begin
        nxt_st = term_pkg::T_IDLE; nxt_trdy = 1'b0; nxt_stop = 1'b0;
        nxt_dev = 1'b0; nxt_oe = 1'b0;
      end
    endcase
  end
  // State registers
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      st_ff <= term_pkg::T_IDLE; trdy_ff <= 1'b0; stop_ff <= 1'b0; dev_ff <= 1'b0;
      oe_ff <= 1'b0; moved_ff <= 1'b0; first_ff <= 1'b0; word_ff <= 1'b0;
      aborted_ff <= 1'b0;
    end else begin
      st_ff <= nxt_st; trdy_ff <= nxt_trdy; stop_ff <= nxt_stop; dev_ff <= nxt_dev;
      oe_ff <= nxt_oe; moved_ff <= nxt_moved; first_ff <= nxt_first; word_ff <= nxt_word;
      aborted_ff <= nxt_abt;
    end
  end
  // Pin drive, active low
  assign bus.trdy_n_o   = ~trdy_ff;
  assign bus.stop_n_o   = ~stop_ff;
  assign bus.devsel_n_o = ~dev_ff;
  assign bus.tgt_oe     = oe_ff;
endmodule // term_target

/* File: sim/tb_top.sv */
`timescale 1ns/100ps
module tb_top;
  logic core_clk, rst_n, claim, busy, buf_full, fatal, mwi, line_end, ready;
  logic start, burst, data_rdy, word_ff, aborted_ff, busy_ff;
  term_pkg::end_kind_type kind_ff;
  int   miscompares, tests_run, cycles, words, xfers;
  // Clock
  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end
  ////////////////////////////////////////
  term_if u_term_if (.core_clk(core_clk));
  term_target u_term_target (.core_clk(core_clk), .rst_n(rst_n), .bus(u_term_if.tgt),
    .claim(claim), .busy(busy), .buf_full(buf_full), .fatal(fatal), .mwi(mwi),
    .line_end(line_end), .ready(ready), .word_ff(word_ff), .aborted_ff(aborted_ff));
  term_master u_term_master (.core_clk(core_clk), .rst_n(rst_n), .bus(u_term_if.mst),
    .start(start), .burst(burst), .data_rdy(data_rdy), .busy_ff(busy_ff), .kind_ff(kind_ff));
  term_chk u_term_chk (.core_clk(core_clk), .rst_n(rst_n), .frame_n(u_term_if.frame_n),
    .irdy_n(u_term_if.irdy_n), .trdy_n(u_term_if.trdy_n), .stop_n(u_term_if.stop_n),
    .devsel_n(u_term_if.devsel_n), .tgt_oe(u_term_if.tgt_oe));
  // Word counters and timeout
  always @(posedge core_clk) begin
    cycles++;
    if (word_ff === 1'b1) words++;
    if (u_term_if.irdy_n === 1'b0 && u_term_if.trdy_n === 1'b0) xfers++;
    if (cycles == 3000) begin
      miscompares++;
      results();
    end
  end
  ////////////////////////////////////////
  task automatic chk_val(input string what, input logic [7:0] exp, input logic [7:0] got);
    tests_run++;
    if (got !== exp) begin
      miscompares++;
      $display("[FAIL] %s expected %0h seen %0h", what, exp, got);
    end
  endtask
  task automatic chk_kind(input term_pkg::end_kind_type exp);
    tests_run++;
    if (kind_ff !== exp) begin
      miscompares++;
      $display("[FAIL] kind expected %0h seen %0h", exp, kind_ff);
    end
  endtask
  // Claim and start together
  task automatic go(input logic b);
    @(posedge core_clk);
    #1 burst = b;
    words = 0;
    xfers = 0;
    start = 1'b1;
    claim = 1'b1;
    @(posedge core_clk);
    #1 start = 1'b0;
    claim = 1'b0;
  endtask
  // Wait for the end; ff means any count
  task automatic fin(input logic [7:0] exp);
    for (int n = 0; n < 60 && busy_ff !== 1'b0; n++) @(posedge core_clk);
    repeat (3) @(posedge core_clk);
    #1 chk_val("oe", 8'h0, {7'h0, u_term_if.tgt_oe});
    chk_val("words", 8'(xfers), 8'(words));
    if (exp != 8'hff) chk_val("xfers", exp, 8'(xfers));
  endtask
  ////////////////////////////////////////
  task automatic t_cond(input int sel, input logic b, input logic [7:0] w,
                        input term_pkg::end_kind_type k);
    {fatal, buf_full, busy} = 3'(1 << sel);
    go(b);
    fin(w);
    chk_kind(k);
    {fatal, buf_full, busy} = 3'h0;
  endtask
  task automatic t_wait;
    {ready, data_rdy, buf_full} = 3'h1;
    go(1'b1);
    repeat (2) @(posedge core_clk);
    #1 chk_val("wait", 8'he, {4'h0, u_term_if.irdy_n, u_term_if.trdy_n, u_term_if.stop_n,
                              u_term_if.devsel_n});
    {ready, data_rdy} = 2'h3;
    fin(8'h1);
    chk_kind(term_pkg::END_DISC);
    buf_full = 1'b0;
  endtask
  task automatic t_mwi;
    mwi = 1'b1;
    buf_full = 1'b1;
    go(1'b1);
    repeat (6) @(posedge core_clk);
    #1 chk_val("stop", 8'h1, {7'h0, u_term_if.stop_n});
    line_end = 1'b1;
    fin(8'hff);
    chk_kind(term_pkg::END_DISC);
    {mwi, buf_full, line_end} = 3'h0;
  endtask
  task automatic t_normal;
    go(1'b1);
    repeat (3) @(posedge core_clk);
    #1 burst = 1'b0;
    fin(8'hff);
    chk_kind(term_pkg::END_DONE);
    chk_val("aborted", 8'h0, {7'h0, aborted_ff});
  endtask
  task automatic results;
    $display("tests_run=%0d miscompares=%0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  // Main sequence
  initial begin
    {rst_n, claim, busy, buf_full, fatal, mwi, line_end, start, burst} = 9'h0;
    {ready, data_rdy} = 2'h3;
    repeat (6) @(posedge core_clk);
    #1 rst_n = 1'b1;
    chk_val("idle", 8'h3, {6'h0, u_term_if.frame_n, u_term_if.irdy_n});
    t_cond(0, 1'b1, 8'h0, term_pkg::END_RETRY);
    t_cond(1, 1'b1, 8'h1, term_pkg::END_DISC);
    t_cond(1, 1'b0, 8'h1, term_pkg::END_DISC);
    t_cond(2, 1'b1, 8'h0, term_pkg::END_ABORT);
    chk_val("aborted", 8'h1, {7'h0, aborted_ff});
    t_wait();
    t_mwi();
    t_normal();
    results();
  end
endmodule // tb_top

/* File: sim/term_chk.sv */
`timescale 1ns/100ps
module term_chk (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst_n,
  // Bus levels
  input wire logic frame_n,
  input wire logic irdy_n,
  input wire logic trdy_n,
  input wire logic stop_n,
  input wire logic devsel_n,
  input wire logic tgt_oe
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  // Last data phase completes on this edge
  wire logic last_done = frame_n && !irdy_n && (!trdy_n || !stop_n);
  ////////////////////////////////////////
  a_stop_held: assert property (!stop_n && !last_done |=> !stop_n)
    else $error("stop released before last phase");
  a_stop_release: assert property (!stop_n && last_done |=> stop_n)
    else $error("stop kept after last phase");
  a_commit_hold: assert property ((!trdy_n || !stop_n) && irdy_n
    |=> $stable({trdy_n, stop_n, devsel_n})) else $error("target changed while committed");
  a_tgt_release: assert property (last_done |=> tgt_oe && trdy_n && stop_n && devsel_n
    ##1 !tgt_oe) else $error("target signals not released");
  a_irdy_drop: assert property (last_done |=> irdy_n)
    else $error("irdy kept after last phase");
  a_frame_at_irdy: assert property (!stop_n && !frame_n ##1 !irdy_n |-> frame_n)
    else $error("frame kept after stop");
  a_abort_shape: assert property ($rose(devsel_n) && !stop_n |-> trdy_n)
    else $error("abort with trdy");
  a_trdy_drop: assert property (!trdy_n && !stop_n && !irdy_n |=> trdy_n)
    else $error("trdy kept after stop phase");
  a_frame_needs_irdy: assert property ($rose(frame_n) |-> !irdy_n)
    else $error("frame dropped without irdy");
endmodule // term_chk
